// ### hdl/bfd_top.sv
// Processor-side banked firmware download engine and address mapper.
`include "bfd_regs.svh"
module bfd_top import bfd_pkg::*; #(
	parameter int AW = 23,
	parameter int PW = 12
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic update_sw_in,
	input wire logic sysfw_sub_in,
	input wire logic host_flag_wr_in,
	input wire logic [13:0] host_flag_addr_in,
	input wire logic [7:0] host_flag_wdata_in,
	output logic [7:0] flags_out,
	output logic [13:0] shm_addr_out,
	output logic shm_rd_out,
	input wire logic [31:0] shm_rdata_in,
	output logic [31:0] ack_out,
	output logic ack_valid_out,
	output logic dl_mode_out,
	output logic [AW-1:0] flash_addr_out,
	output logic [7:0] flash_wdata_out,
	output logic flash_rd_out,
	output logic flash_we_out,
	output logic flash_erase_out,
	input wire logic [7:0] flash_rdata_in,
	input wire logic flash_busy_in,
	input wire logic cpu_req_in,
	input wire logic cpu_wr_in,
	input wire logic [31:0] cpu_addr_in,
	input wire logic [31:0] cpu_wdata_in,
	input wire logic [31:0] bar_in,
	output bfd_region_t region_out,
	output logic [31:0] pci_addr_out,
	output logic bar_io_out
);
	localparam int SL = `BFD_SECT_LSB;
	localparam int BL = `BFD_BANK_LSB;

	// ------------------------------------------------------------
	// Signals.
	// ------------------------------------------------------------
	bfd_state_t state_q;
	bfd_phase_t phase_q;
	logic [3:0] host_q;
	logic [3:0] proc_q;
	logic [3:0] host_claim;
	logic strap_done_q;
	logic sub_q;
	logic [PW-1:0] ptr_q;
	logic [1:0] bank;
	logic [31:0] word_q;
	logic [31:0] cmd_q;
	logic [31:0] arg_q;
	logic [AW-1:0] ofs_q;
	logic [1:0] bi_q;
	logic [31:0] crc_q;
	logic [31:0] crc_nx;
	logic [7:0] cur_byte;
	logic bad_q;
	logic first_q;
	logic erased_q;
	logic need_erase;
	logic ers_ok;
	logic fl_go;
	logic fl_er;
	logic fl_busy;
	logic [AW-1:0] fl_addr;
	logic cfg_ok_q;
	logic [31:0] cfg_q;

	assign flags_out = {proc_q, host_q};
	assign bank = ptr_q[BL+1:BL];
	assign cur_byte = word_q[8*bi_q +: 8];
	assign need_erase = sub_q && (first_q || ofs_q[SL-1:0] == '0) && !erased_q;
	assign ers_ok = (arg_q[31:AW-SL] == '0) && (sub_q || arg_q[AW-SL-1:0] != '0);
	assign host_claim = (host_flag_wr_in && host_flag_addr_in == `BFD_FLAG_OFS) ?
		host_flag_wdata_in[3:0] : 4'h0;

	// ------------------------------------------------------------
	// Mode straps.
	// ------------------------------------------------------------
	// switch at reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			strap_done_q <= 1'b0;
			dl_mode_out <= 1'b0;
			sub_q <= 1'b0;
		end else if (ce_in && !strap_done_q) begin
			strap_done_q <= 1'b1;
			dl_mode_out <= !update_sw_in;
			sub_q <= sysfw_sub_in;
		end
	end

	// ------------------------------------------------------------
	// Host ownership flags.
	// ------------------------------------------------------------
	// host claim fails
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			host_q <= 4'h0;
		end else if (ce_in && host_flag_wr_in && host_flag_addr_in == `BFD_FLAG_OFS) begin
			host_q <= host_flag_wdata_in[3:0] & ~proc_q;
		end
	end

	// ------------------------------------------------------------
	// Payload CRC.
	// ------------------------------------------------------------
	bfd_crc_step #(
		.POLY(`BFD_CRC_POLY)
	) u_crc (
		.crc_in(crc_q),
		.byte_in(cur_byte),
		.crc_out(crc_nx)
	);

	// ------------------------------------------------------------
	// Flash sequencer requests.
	// ------------------------------------------------------------
	// gated writes
	always_comb begin
		fl_go = 1'b0;
		fl_er = 1'b0;
		fl_addr = ofs_q;
		if (state_q == S_BYTE && !bad_q) begin
			fl_go = 1'b1;
			fl_er = need_erase;
		end else if (state_q == S_CHK && cmd_q == `BFD_CMD_ERASE && !bad_q &&
			word_q == crc_q && ers_ok) begin
			fl_go = 1'b1;
			fl_er = 1'b1;
			fl_addr = {arg_q[AW-SL-1:0], {SL{1'b0}}};
		end
	end

	bfd_flash_ctl #(
		.AW(AW)
	) u_flash (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.start_in(fl_go),
		.erase_in(fl_er),
		.addr_in(fl_addr),
		.data_in(cur_byte),
		.busy_out(fl_busy),
		.flash_addr_out(flash_addr_out),
		.flash_wdata_out(flash_wdata_out),
		.flash_rd_out(flash_rd_out),
		.flash_we_out(flash_we_out),
		.flash_erase_out(flash_erase_out),
		.flash_rdata_in(flash_rdata_in),
		.flash_busy_in(flash_busy_in)
	);

	// ------------------------------------------------------------
	// Download sequencer.
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= S_OFF;
			phase_q <= PH_CMD;
			proc_q <= 4'h0;
			ptr_q <= '0;
			word_q <= 32'h0000_0000;
			cmd_q <= 32'h0000_0000;
			arg_q <= 32'h0000_0000;
			ofs_q <= '0;
			bi_q <= 2'h0;
			crc_q <= `BFD_CRC_INIT;
			bad_q <= 1'b0;
			first_q <= 1'b1;
			erased_q <= 1'b0;
			shm_rd_out <= 1'b0;
			shm_addr_out <= 14'h0000;
			ack_out <= 32'h0000_0000;
			ack_valid_out <= 1'b0;
		end else if (ce_in) begin
			unique case (state_q)
				S_OFF: begin
					if (strap_done_q && dl_mode_out) begin
						state_q <= S_WAIT0;
					end
				end
				S_WAIT0: begin
					if (host_q[0] && !host_q[3] && !host_claim[3]) begin
						proc_q[3] <= 1'b1;
						ack_valid_out <= 1'b0;
						ptr_q <= '0;
						phase_q <= PH_CMD;
						crc_q <= `BFD_CRC_INIT;
						bad_q <= 1'b0;
						first_q <= 1'b1;
						erased_q <= 1'b0;
						state_q <= S_RD;
					end
				end
				S_RD: begin
					if (proc_q[bank]) begin
						shm_rd_out <= 1'b1;
						shm_addr_out <= {ptr_q, 2'b00};
						state_q <= S_RDW;
					end else if (!host_q[bank] && !host_claim[bank]) begin
						proc_q[bank] <= 1'b1;
						state_q <= S_REL;
					end
				end
				S_REL: begin
					proc_q[bank - 2'h1] <= 1'b0;
					state_q <= S_RD;
				end
				S_RDW: begin
					shm_rd_out <= 1'b0;
					state_q <= S_RDD;
				end
				S_RDD: begin
					word_q <= shm_rdata_in;
					ptr_q <= ptr_q + 1'b1;
					state_q <= S_PARSE;
				end
				S_PARSE: begin
					state_q <= S_RD;
					unique case (phase_q)
						PH_CMD: begin
							cmd_q <= word_q;
							phase_q <= PH_ARG;
						end
						PH_ARG: begin
							arg_q <= word_q;
							if (word_q == 32'h0000_0000 && cmd_q == `BFD_CMD_PROG) begin
								phase_q <= PH_ADDR;
							end else if (cmd_q == `BFD_CMD_PROG) begin
								phase_q <= PH_ADDR;
							end else begin
								bad_q <= (cmd_q != `BFD_CMD_ERASE);
								phase_q <= PH_CRC;
							end
						end
						PH_ADDR: begin
							ofs_q <= word_q[AW-1:0];
							bi_q <= 2'h0;
							if (word_q[31:AW] != '0 || (!sub_q && word_q[AW-1:SL] == '0)) begin
								bad_q <= 1'b1;
							end
							phase_q <= (arg_q == 32'h0000_0000) ? PH_CRC : PH_DATA;
						end
						PH_DATA: begin
							state_q <= S_BYTE;
						end
						PH_CRC: begin
							state_q <= S_CHK;
						end
					endcase
				end
				S_BYTE: begin
					if (!bad_q && need_erase) begin
						erased_q <= 1'b1;
						state_q <= S_FLW;
					end else begin
						crc_q <= crc_nx;
						ofs_q <= ofs_q + 1'b1;
						arg_q <= arg_q - 32'h0000_0001;
						bi_q <= bi_q + 2'h1;
						first_q <= 1'b0;
						erased_q <= 1'b0;
						state_q <= bad_q ? S_NXT : S_FLW;
					end
				end
				S_FLW: begin
					if (!fl_busy) begin
						state_q <= erased_q ? S_BYTE : S_NXT;
					end
				end
				S_NXT: begin
					if (arg_q == 32'h0000_0000) begin
						phase_q <= PH_CRC;
						state_q <= S_RD;
					end else begin
						state_q <= (bi_q == 2'h0) ? S_RD : S_BYTE;
					end
				end
				S_CHK: begin
					if (bad_q || word_q != crc_q || (cmd_q == `BFD_CMD_ERASE && !ers_ok)) begin
						bad_q <= 1'b1;
						ack_out <= `BFD_NACK;
					end else begin
						ack_out <= `BFD_ACK;
					end
					state_q <= S_EWT;
				end
				S_EWT: begin
					if (!fl_busy) begin
						state_q <= S_DONE;
					end
				end
				S_DONE: begin
					proc_q <= 4'h0;
					ack_valid_out <= 1'b1;
					state_q <= S_HREL;
				end
				S_HREL: begin
					if (host_q == 4'h0) begin
						state_q <= S_WAIT0;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Processor address mapping.
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			region_out <= RG_NONE;
			pci_addr_out <= 32'h0000_0000;
			cfg_q <= 32'h0000_0000;
			cfg_ok_q <= 1'b0;
			bar_io_out <= 1'b0;
		end else if (ce_in) begin
			bar_io_out <= bar_in[`BFD_BAR_IO];
			if (!cpu_req_in) begin
				region_out <= RG_NONE;
			end else if (cpu_addr_in[31:24] == `BFD_TOP_FLASH) begin
				region_out <= RG_FLASH;
				pci_addr_out <= cpu_addr_in - `BFD_FLASH_BASE;
			end else if (cpu_addr_in == `BFD_CFG_ADDR) begin
				region_out <= RG_CFGA;
				if (cpu_wr_in) begin
					cfg_q <= cpu_wdata_in;
					cfg_ok_q <= 1'b1;
				end
			end else if (cpu_addr_in == `BFD_CFG_DATA) begin
				region_out <= cfg_ok_q ? RG_CFGD : RG_REJ;
				pci_addr_out <= cfg_q;
			end else if (cpu_addr_in[31:24] == `BFD_TOP_IO) begin
				region_out <= RG_IO;
				pci_addr_out <= cpu_addr_in - `BFD_IO_BASE;
			end else begin
				region_out <= RG_MEM;
				pci_addr_out <= cpu_addr_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	excl_own_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(host_q & proc_q) == 4'h0)
		else $error("Bank owned by both parties.");
	strap_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		strap_done_q |=> $stable(dl_mode_out) && $stable(sub_q))
		else $error("Download mode changed after reset.");
	own_read_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		shm_rd_out |-> proc_q[shm_addr_out[13:12]])
		else $error("Read of a bank not owned.");
	keep_one_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		($past(proc_q) != 4'h0 && state_q != S_HREL) |-> proc_q != 4'h0)
		else $error("Current bank released before next was held.");
	release_all_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		ack_valid_out |-> proc_q == 4'h0)
		else $error("Result reported while a bank is held.");
	nack_bad_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(ack_valid_out && bad_q) |-> ack_out == `BFD_NACK)
		else $error("Failed command not answered with NACK.");
	no_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		bad_q |-> !fl_go && !flash_we_out && !flash_erase_out)
		else $error("Flash write after a failed check.");
	sect0_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(fl_go && !sub_q) |-> fl_addr[AW-1:SL] != '0)
		else $error("Sector 0 touched outside submode.");
	flash_map_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		($past(ce_in && cpu_req_in) && $past(cpu_addr_in[31:24]) == `BFD_TOP_FLASH) |->
		region_out == RG_FLASH && pci_addr_out == $past(cpu_addr_in) - `BFD_FLASH_BASE)
		else $error("Flash window mapped wrongly.");
	cfg_seq_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		region_out == RG_CFGD |-> cfg_ok_q && pci_addr_out == cfg_q)
		else $error("Config data access without address.");
endmodule

// ### hdl/bfd_regs.svh
// Offsets, constants and codes of the banked firmware download block.
// How it works
// - Flash is split into consecutive 64 KB sectors by offset bits above bit 15.
// - Flash offset zero sits at processor address ff00_0000, linear above.
// - Every flash program access carries exactly one byte.
// - Programming only clears bits; the written byte is old data ANDed with new.
// - Erase always covers one whole sector, with a sector-aligned address.
// - A base address value with bit 0 set is I/O, else memory.
// - Memory addresses pass unchanged; I/O space is reached at fe00_0000 plus offset.
// - Configuration data at fee0_0000 works only after the address at fec0_0000 is written.
// - Download mode is entered when the update switch is off at reset.
// - Shared memory is four 4 KB banks, chosen by word index bits 11 and 10.
// - Each bank has host and processor flags; a claim fails if the other owns it.
// - Wait for host on bank 0, then claim bank 3 to show readiness.
// - Claim a bank freed by the host before reading, then release the previous one.
// - Banks are visited strictly in order 0, 1, 2, 3 and round again.
// - A command is a code word, a body, and a closing CRC word.
// - After the CRC word the block reports an ACK or NACK value.
// - All processor ownership flags are dropped in the same cycle the result is reported.
// - Program start is a flash offset outside sector 0 unless in firmware submode.
// - Sectors are erased before programming only in the firmware submode.
// - Erase command erases the named sector; sector 0 only in firmware submode.
// - The CRC runs over the payload bytes alone.
// - CRC starts at zero, shifts in each byte, XORs a table entry of 04c11db7.
`ifndef BFD_REGS_SVH
`define BFD_REGS_SVH
`define BFD_FLAG_OFS 14'h04c0
`define BFD_SECT_LSB 16
`define BFD_BANK_LSB 10
`define BFD_FLASH_BASE 32'hff00_0000
`define BFD_IO_BASE 32'hfe00_0000
`define BFD_CFG_ADDR 32'hfec0_0000
`define BFD_CFG_DATA 32'hfee0_0000
`define BFD_TOP_FLASH 8'hff
`define BFD_TOP_IO 8'hfe
`define BFD_BAR_IO 0
`define BFD_CRC_POLY 32'h04c1_1db7
`define BFD_CRC_INIT 32'h0000_0000
`define BFD_CMD_PROG 32'h0000_0001
`define BFD_CMD_ERASE 32'h0000_0002
`define BFD_ACK 32'h0000_0006
`define BFD_NACK 32'h0000_0015
`endif

// ### hdl/bfd_pkg.sv
// Types shared by the banked firmware download block.
package bfd_pkg;
	typedef enum logic [3:0] {S_OFF, S_WAIT0, S_RD, S_REL, S_RDW, S_RDD, S_PARSE,
		S_BYTE, S_FLW, S_NXT, S_CHK, S_EWT, S_DONE, S_HREL} bfd_state_t;
	typedef enum logic [2:0] {PH_CMD, PH_ARG, PH_ADDR, PH_DATA, PH_CRC} bfd_phase_t;
	typedef enum logic [2:0] {RG_NONE, RG_MEM, RG_IO, RG_FLASH, RG_CFGA, RG_CFGD,
		RG_REJ} bfd_region_t;
	typedef enum logic [2:0] {F_IDLE, F_RD, F_MRG, F_GO, F_WAIT} bfd_fstate_t;
endpackage

// ### hdl/bfd_crc_step.sv
// One byte step of the download CRC.
`include "bfd_regs.svh"
module bfd_crc_step #(
	parameter logic [31:0] POLY = `BFD_CRC_POLY
) (
	input wire logic [31:0] crc_in,
	input wire logic [7:0] byte_in,
	output logic [31:0] crc_out
);
	// Table entry built by eight right shifts of the index.
	function automatic logic [31:0] entry(input logic [7:0] idx);
		logic [31:0] c;
		c = {24'h00_0000, idx};
		for (int j = 0; j < 8; j++) begin
			c = c[0] ? ((c >> 1) ^ POLY) : (c >> 1);
		end
		return c;
	endfunction

	assign crc_out = {crc_in[23:0], byte_in} ^ entry(crc_in[31:24]);
endmodule

// ### hdl/bfd_flash_ctl.sv
// Byte-wide flash program and sector erase sequencer.
`include "bfd_regs.svh"
module bfd_flash_ctl import bfd_pkg::*; #(
	parameter int AW = 23
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic erase_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [7:0] data_in,
	output logic busy_out,
	output logic [AW-1:0] flash_addr_out,
	output logic [7:0] flash_wdata_out,
	output logic flash_rd_out,
	output logic flash_we_out,
	output logic flash_erase_out,
	input wire logic [7:0] flash_rdata_in,
	input wire logic flash_busy_in
);
	localparam int SL = `BFD_SECT_LSB;
	bfd_fstate_t st_q;
	logic [7:0] data_q;
	logic [7:0] old_q;

	assign busy_out = (st_q != F_IDLE);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			st_q <= F_IDLE;
			flash_addr_out <= '0;
			flash_wdata_out <= 8'h00;
			flash_rd_out <= 1'b0;
			flash_we_out <= 1'b0;
			flash_erase_out <= 1'b0;
			data_q <= 8'h00;
			old_q <= 8'hff;
		end else if (ce_in) begin
			unique case (st_q)
				F_IDLE: begin
					if (start_in && erase_in) begin
						flash_addr_out <= {addr_in[AW-1:SL], {SL{1'b0}}};
						flash_erase_out <= 1'b1;
						st_q <= F_GO;
					end else if (start_in) begin
						flash_addr_out <= addr_in;
						data_q <= data_in;
						flash_rd_out <= 1'b1;
						st_q <= F_RD;
					end
				end
				F_RD: begin
					flash_rd_out <= 1'b0;
					st_q <= F_MRG;
				end
				F_MRG: begin
					old_q <= flash_rdata_in;
					flash_wdata_out <= data_q & flash_rdata_in;
					flash_we_out <= 1'b1;
					st_q <= F_GO;
				end
				F_GO: begin
					flash_we_out <= 1'b0;
					flash_erase_out <= 1'b0;
					st_q <= F_WAIT;
				end
				F_WAIT: begin
					if (!flash_busy_in) begin
						st_q <= F_IDLE;
					end
				end
			endcase
		end
	end

	clear_only_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		flash_we_out |-> ((flash_wdata_out & ~old_q) == 8'h00))
		else $error("Program would raise a flash bit.");
	erase_align_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		flash_erase_out |-> (flash_addr_out[SL-1:0] == '0) && !flash_we_out)
		else $error("Erase address is not sector aligned.");
endmodule

// ### tb/bfd_host_model.sv
// Host-side partner model: shared memory words and flag register writes.
`include "bfd_regs.svh"
module bfd_host_model (
	input wire logic sys_clk_in,
	input wire logic [13:0] shm_addr_in,
	input wire logic shm_rd_in,
	output logic [31:0] shm_rdata_out,
	output logic host_flag_wr_out,
	output logic [13:0] host_flag_addr_out,
	output logic [7:0] host_flag_wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:4095];
	initial begin
		shm_rdata_out = 32'h0;
		host_flag_wr_out = 1'b0;
		host_flag_addr_out = `BFD_FLAG_OFS;
		host_flag_wdata_out = 8'h00;
	end
	// four banks.
	// Read data stands one cycle, then the released bus is scrambled.
	always @(posedge sys_clk_in) begin
		if (shm_rd_in)
			shm_rdata_out <= mem[shm_addr_in[13:2]];
		else
			shm_rdata_out <= ~shm_rdata_out;
	end
	task automatic put(input int idx, input logic [31:0] val);
		mem[idx % 4096] = val;
	endtask
	task automatic set_flags(input logic [7:0] v, input logic [13:0] a = `BFD_FLAG_OFS);
		@(posedge sys_clk_in);
		host_flag_wr_out <= 1'b1;
		host_flag_addr_out <= a;
		host_flag_wdata_out <= v;
		@(posedge sys_clk_in);
		host_flag_wr_out <= 1'b0;
		host_flag_wdata_out <= ~v;
	endtask
endmodule

// ### tb/test_banked_firmware_download.sv
// Self-checking bench for the banked firmware download block.
`include "bfd_regs.svh"
module test_banked_firmware_download import bfd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in, rst_in, ce_in, update_sw_in, sysfw_sub_in, host_flag_wr_in;
	logic shm_rd_out, ack_valid_out, dl_mode_out, bar_io_out, cpu_req_in, cpu_wr_in;
	logic flash_rd_out, flash_we_out, flash_erase_out, flash_busy_in;
	logic [13:0] host_flag_addr_in, shm_addr_out;
	logic [7:0] host_flag_wdata_in, flags_out, flash_wdata_out, flash_rdata_in;
	logic [31:0] shm_rdata_in, ack_out, cpu_addr_in, cpu_wdata_in, bar_in, pci_addr_out;
	logic [22:0] flash_addr_out, er_addr;
	bfd_region_t region_out;
	int bad_count = 0, n_compared = 0, cycles = 0, n_we = 0, n_er = 0, bcnt = 0;
	logic [7:0] fmem [int];
	logic [31:0] crc_tab [0:255];
	bfd_top bfd_top_inst (.sys_clk_in, .rst_in, .ce_in, .update_sw_in, .sysfw_sub_in,
		.host_flag_wr_in, .host_flag_addr_in, .host_flag_wdata_in, .flags_out,
		.shm_addr_out, .shm_rd_out, .shm_rdata_in, .ack_out, .ack_valid_out, .dl_mode_out,
		.flash_addr_out, .flash_wdata_out, .flash_rd_out, .flash_we_out, .flash_erase_out,
		.flash_rdata_in, .flash_busy_in, .cpu_req_in, .cpu_wr_in, .cpu_addr_in,
		.cpu_wdata_in, .bar_in, .region_out, .pci_addr_out, .bar_io_out);
	bfd_host_model bfd_host_model_inst (.sys_clk_in(sys_clk_in), .shm_addr_in(shm_addr_out),
		.shm_rd_in(shm_rd_out), .shm_rdata_out(shm_rdata_in),
		.host_flag_wr_out(host_flag_wr_in), .host_flag_addr_out(host_flag_addr_in),
		.host_flag_wdata_out(host_flag_wdata_in));
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	// ----------------------------------------
	// Flash model and run limit
	// ----------------------------------------
	always @(posedge sys_clk_in) begin
		flash_rdata_in <= ~flash_rdata_in;
		if (flash_rd_out)
			flash_rdata_in <= fmem.exists(flash_addr_out) ? fmem[flash_addr_out] : 8'hff;
		if (flash_we_out) begin
			fmem[flash_addr_out] = flash_wdata_out;
			n_we++;
		end
		if (flash_erase_out) begin
			n_er++;
			er_addr <= flash_addr_out;
		end
		bcnt <= (flash_we_out || flash_erase_out) ? 2 : (bcnt > 0 ? bcnt - 1 : 0);
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			$display("[ERR] %0t run limit reached", $time);
			tally_and_finish();
		end
	end
	assign flash_busy_in = (bcnt != 0);
	task automatic tally_and_finish();
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask
	function automatic logic [31:0] crc_of(input logic [7:0] d[$]);
		logic [31:0] c;
		c = 32'h0;
		foreach (d[i])
			c = {c[23:0], d[i]} ^ crc_tab[c[31:24]];
		return c;
	endfunction
	task automatic do_reset(input logic sw, input logic sub);
		@(posedge sys_clk_in);
		rst_in <= 1'b1;
		update_sw_in <= sw;
		sysfw_sub_in <= sub;
		repeat (10) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		#1 chk(dl_mode_out, !sw, "mode");
		chk(flags_out, 8'h00, "flags after reset");
	endtask
	task automatic wait_flag(input int i);
		int k;
		k = 0;
		while (flags_out[i] !== 1'b1 && k < 20000) begin
			@(posedge sys_clk_in);
			#1 k++;
		end
		chk(k < 20000, 1, "bank claim");
	endtask
	// ----------------------------------------
	// Host side of one command
	// ----------------------------------------
	task automatic run_cmd(input logic [31:0] w[$], input logic [31:0] exp);
		int nb, nx, k;
		nb = (w.size() + 1023) / 1024;
		foreach (w[i])
			bfd_host_model_inst.put(i, w[i]);
		bfd_host_model_inst.set_flags(8'h01);
		wait_flag(7);
		for (int b = 0; b < nb; b++) begin
			nx = (b + 1) % 4;
			bfd_host_model_inst.set_flags(8'((1 << b) | (1 << nx) | (b == 0 ? 8 : 0)));
			#1 if (b == 0)
				chk(flags_out, 8'h83, "claim of owned bank");
			bfd_host_model_inst.set_flags(8'(1 << nx));
			wait_flag(4 + b);
		end
		k = 0;
		while (ack_valid_out !== 1'b1 && k < 8000) begin
			@(posedge sys_clk_in);
			#1 k++;
		end
		chk(ack_out, exp, "answer");
		chk(flags_out[7:4], 4'h0, "processor flags");
		bfd_host_model_inst.set_flags(8'h00);
		repeat (3) @(posedge sys_clk_in);
	endtask
	task automatic prog(input logic [22:0] off, input logic [7:0] d[$], input bit bad,
		input logic [31:0] exp);
		logic [31:0] w[$];
		logic [31:0] x;
		w = {`BFD_CMD_PROG, 32'(d.size()), 32'(off)};
		for (int i = 0; i < d.size(); i += 4) begin
			x = 32'h0;
			for (int j = 0; j < 4 && i + j < d.size(); j++)
				x[8*j +: 8] = d[i + j];
			w.push_back(x);
		end
		w.push_back(crc_of(d) ^ {31'h0, bad});
		run_cmd(w, exp);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic map1(input logic [31:0] a, input logic wr, input logic [31:0] wd,
		input bfd_region_t r, input logic [31:0] p);
		@(posedge sys_clk_in);
		cpu_req_in <= 1'b1;
		cpu_wr_in <= wr;
		cpu_addr_in <= a;
		cpu_wdata_in <= wd;
		bar_in <= a;
		@(posedge sys_clk_in);
		cpu_req_in <= 1'b0;
		#1 chk(region_out, r, "region");
		if (r != RG_REJ && r != RG_CFGA)
			chk(pci_addr_out, p, "bus address");
		chk(bar_io_out, a[0], "space kind");
		@(posedge sys_clk_in);
		#1 chk(region_out, RG_NONE, "idle region");
	endtask
	task automatic t_map();
		map1(32'hfee0_0000, 1'b0, 32'h0, RG_REJ, 32'h0);
		map1(32'hff01_0001, 1'b0, 32'h0, RG_FLASH, 32'h0001_0001);
		map1(32'hfe80_0000, 1'b1, 32'h0, RG_IO, 32'h0080_0000);
		map1(32'h9000_0003, 1'b0, 32'h0, RG_MEM, 32'h9000_0003);
		map1(32'hfec0_0000, 1'b1, 32'h8000_0810, RG_CFGA, 32'h0);
		map1(32'hfee0_0000, 1'b0, 32'h0, RG_CFGD, 32'h8000_0810);
	endtask
	task automatic t_prog();
		int we0;
		we0 = n_we;
		fmem[23'h010011] = 8'h0f;
		prog(23'h010010, {8'ha5, 8'hf3, 8'h3c, 8'h81, 8'h7e, 8'h42}, 0, `BFD_ACK);
		chk(n_we - we0, 6, "byte writes");
		chk(fmem[23'h010011], 8'h03, "cleared bits");
		chk(fmem[23'h010015], 8'h42, "last byte");
		prog(23'h020000, {8'h11, 8'h22, 8'h33, 8'h44}, 1, `BFD_NACK);
		chk(n_er, 0, "erase outside submode");
	endtask
	task automatic t_erase();
		int er0;
		er0 = n_er;
		run_cmd({`BFD_CMD_ERASE, 32'h2, 32'h0}, `BFD_ACK);
		chk(n_er - er0, 1, "erase count");
		chk(er_addr, 23'h020000, "erase address");
		run_cmd({`BFD_CMD_ERASE, 32'h0, 32'h0}, `BFD_NACK);
		run_cmd({32'h0000_0007, 32'h0}, `BFD_NACK);
		chk(n_er - er0, 1, "refused erase");
	endtask
	task automatic t_cross();
		logic [7:0] d[$];
		int we0;
		we0 = n_we;
		repeat (4084) d.push_back(8'h00);
		prog(23'h000100, d, 0, `BFD_NACK);
		chk(n_we - we0, 0, "writes to sector 0");
	endtask
	task automatic t_sub();
		int er0;
		er0 = n_er;
		run_cmd({`BFD_CMD_ERASE, 32'h0, 32'h0}, `BFD_ACK);
		chk(er_addr, 23'h000000, "sector 0 erase");
		prog(23'h030000, {8'h5a}, 0, `BFD_ACK);
		chk(n_er - er0, 2, "erase before program");
		chk(er_addr, 23'h030000, "program sector erase");
		chk(fmem[23'h030000], 8'h5a, "submode byte");
	endtask
	initial begin
		logic [31:0] t;
		rst_in = 1'b1;
		ce_in = 1'b1;
		update_sw_in = 1'b0;
		sysfw_sub_in = 1'b0;
		cpu_req_in = 1'b0;
		cpu_wr_in = 1'b0;
		cpu_addr_in = 32'h0;
		cpu_wdata_in = 32'h0;
		bar_in = 32'h0;
		flash_rdata_in = 8'h00;
		for (int i = 0; i < 256; i++) begin
			t = i;
			repeat (8) t = t[0] ? (t >> 1) ^ `BFD_CRC_POLY : t >> 1;
			crc_tab[i] = t;
		end
		do_reset(1'b0, 1'b0);
		bfd_host_model_inst.set_flags(8'h0f, 14'h04c4);
		#1 chk(flags_out, 8'h00, "write to other offset");
		@(posedge sys_clk_in);
		ce_in <= 1'b0;
		bfd_host_model_inst.set_flags(8'h0f);
		#1 chk(flags_out, 8'h00, "write while frozen");
		@(posedge sys_clk_in);
		ce_in <= 1'b1;
		t_map();
		t_prog();
		t_erase();
		t_cross();
		do_reset(1'b1, 1'b0);
		bfd_host_model_inst.set_flags(8'h01);
		repeat (5) @(posedge sys_clk_in);
		#1 chk(flags_out, 8'h01, "no download outside mode");
		do_reset(1'b0, 1'b1);
		t_sub();
		tally_and_finish();
	end
endmodule
